// file: design/pcd_crossbar.sv
// Priority crossbar decoder with its routing and skip registers on APB
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module pcd_crossbar (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic spi_four_wire,
    input wire pcd_pkg::pcd_periph_t periph_out,
    output logic [pcd_pkg::NSLOT-1:0] periph_in,
    input wire logic [pcd_pkg::NPIN-1:0] gpio_out,
    input wire logic [pcd_pkg::NPIN-1:0] pin_push_pull,
    output logic [pcd_pkg::NPIN-1:0] gpio_in,
    input wire logic [pcd_pkg::NPIN-1:0] pad_in,
    output pcd_pkg::pcd_pad_t pad
);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    // Asynchronous assert, two-flop release
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end
    assign rst_n = rst_sync[1];

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [5:0] crossbar_route_first;
    logic [5:0] crossbar_route_second;
    logic crossbar_enable_bit;
    logic [pcd_pkg::NPIN-1:0] pin_skip_mask;
    logic [pcd_pkg::NPIN-1:0] pin_assigned;
    logic [9:0] reg_idx;
    logic mapped;
    logic wr_take;

    assign reg_idx = paddr[11:2];
    assign mapped = (paddr[1:0] == 2'b00) &&
                    (reg_idx == pcd_pkg::IDX_ROUTE_FIRST || reg_idx == pcd_pkg::IDX_ROUTE_SECOND ||
                     reg_idx == pcd_pkg::IDX_ROUTE_THIRD || reg_idx == pcd_pkg::IDX_SKIP_P0 ||
                     reg_idx == pcd_pkg::IDX_SKIP_P1 || reg_idx == pcd_pkg::IDX_ASSIGNED);
    assign wr_take = psel && penable && pready && pwrite && mapped;

    // One wait-free answer: pready rises in the first access cycle
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // Read data captured in the setup cycle; unused bits read zero
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            prdata <= 32'h00000000;
        else if (psel && !penable)
        begin
            prdata <= 32'h00000000;
            unique case (reg_idx)
                pcd_pkg::IDX_ROUTE_FIRST: prdata[5:0] <= crossbar_route_first;
                pcd_pkg::IDX_ROUTE_SECOND: prdata[5:0] <= crossbar_route_second;
                pcd_pkg::IDX_ROUTE_THIRD: prdata[pcd_pkg::B_XBAR_EN] <= crossbar_enable_bit;
                pcd_pkg::IDX_SKIP_P0: prdata[7:0] <= pin_skip_mask[7:0];
                pcd_pkg::IDX_SKIP_P1: prdata[7:0] <= pin_skip_mask[15:8];
                pcd_pkg::IDX_ASSIGNED: prdata[15:0] <= pin_assigned;
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // First two routing registers keep only six bits, the third only bit 6; all other write bits are dropped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            crossbar_route_first <= pcd_pkg::ROUTE_RESET;
            crossbar_route_second <= pcd_pkg::ROUTE_RESET;
            crossbar_enable_bit <= pcd_pkg::XBAR_EN_RESET;
        end
        else if (wr_take)
        begin
            if (reg_idx == pcd_pkg::IDX_ROUTE_FIRST)
                crossbar_route_first <= pwdata[5:0];
            if (reg_idx == pcd_pkg::IDX_ROUTE_SECOND)
                crossbar_route_second <= pwdata[5:0];
            if (reg_idx == pcd_pkg::IDX_ROUTE_THIRD)
                crossbar_enable_bit <= pwdata[pcd_pkg::B_XBAR_EN];
        end
    end

    // Per-pin skip bits, one byte per port
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_skip_mask <= {pcd_pkg::SKIP_RESET, pcd_pkg::SKIP_RESET};
        else if (wr_take)
        begin
            if (reg_idx == pcd_pkg::IDX_SKIP_P0)
                pin_skip_mask[7:0] <= pwdata[7:0];
            if (reg_idx == pcd_pkg::IDX_SKIP_P1)
                pin_skip_mask[15:8] <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // Slot enables
    // ----------------------------------------
    logic [pcd_pkg::NSLOT-1:0] slot_en;
    logic [1:0] cap_count;

    // Capture channel count; reserved codes route nothing
    always_comb
    begin
        unique case (crossbar_route_second[pcd_pkg::B_CAP_LSB +: 3])
            3'h1: cap_count = 2'h1;
            3'h2: cap_count = 2'h2;
            3'h3: cap_count = 2'h3;
            default: cap_count = 2'h0;
        endcase
    end

    // Signal order inside each function is fixed
    always_comb
    begin
        slot_en = '0;
        slot_en[pcd_pkg::S_UTX] = crossbar_route_first[pcd_pkg::B_UART];
        slot_en[pcd_pkg::S_URX] = crossbar_route_first[pcd_pkg::B_UART];
        slot_en[pcd_pkg::S_SCK +: 3] = {3{crossbar_route_first[pcd_pkg::B_SPI]}};
        slot_en[pcd_pkg::S_NSS] = crossbar_route_first[pcd_pkg::B_SPI] && spi_four_wire;
        slot_en[pcd_pkg::S_SDA] = crossbar_route_first[pcd_pkg::B_SMB];
        slot_en[pcd_pkg::S_SCL] = crossbar_route_first[pcd_pkg::B_SMB];
        slot_en[pcd_pkg::S_CMP_SYNC] = crossbar_route_first[pcd_pkg::B_CMP_SYNC];
        slot_en[pcd_pkg::S_CMP_ASYNC] = crossbar_route_first[pcd_pkg::B_CMP_ASYNC];
        slot_en[pcd_pkg::S_SYSTEM_CLOCK_SIGNAL] = crossbar_route_first[pcd_pkg::B_SYSTEM_CLOCK_SIGNAL];
        slot_en[pcd_pkg::S_CAPTURE_CHANNEL_IO_0] = cap_count >= 2'h1;
        slot_en[pcd_pkg::S_CAPTURE_CHANNEL_IO_0 + 1] = cap_count >= 2'h2;
        slot_en[pcd_pkg::S_CAPTURE_CHANNEL_IO_0 + 2] = cap_count >= 2'h3;
        slot_en[pcd_pkg::S_ECI] = crossbar_route_second[pcd_pkg::B_ECI];
        slot_en[pcd_pkg::S_T0] = crossbar_route_second[pcd_pkg::B_T0];
        slot_en[pcd_pkg::S_T1] = crossbar_route_second[pcd_pkg::B_T1];
    end

    // ----------------------------------------
    // Priority allocation
    // ----------------------------------------
    logic [pcd_pkg::NPIN-1:0][4:0] next_pin_owner;
    logic [pcd_pkg::NPIN-1:0][4:0] pin_owner;
    logic [pcd_pkg::NSLOT-1:0][3:0] next_slot_pin;
    logic [pcd_pkg::NSLOT-1:0][3:0] slot_pin;
    logic [pcd_pkg::NSLOT-1:0] next_slot_placed;
    logic [pcd_pkg::NSLOT-1:0] slot_placed;

    // Walk slots in priority order, each taking the lowest free pin; a slot
    // with no free pin left is simply not placed
    always_comb
    begin
        logic [pcd_pkg::NPIN-1:0] used;
        logic found;
        used = pin_skip_mask;
        found = 1'b0;
        next_pin_owner = {pcd_pkg::NPIN{pcd_pkg::OWNER_GPIO}};
        next_slot_pin = '0;
        next_slot_placed = '0;
        // Fixed serial port pins ignore the skip bits
        if (slot_en[pcd_pkg::S_UTX])
        begin
            used[pcd_pkg::UART_TX_PIN] = 1'b1;
            used[pcd_pkg::UART_RX_PIN] = 1'b1;
            next_pin_owner[pcd_pkg::UART_TX_PIN] = 5'(pcd_pkg::S_UTX);
            next_pin_owner[pcd_pkg::UART_RX_PIN] = 5'(pcd_pkg::S_URX);
            next_slot_pin[pcd_pkg::S_UTX] = 4'(pcd_pkg::UART_TX_PIN);
            next_slot_pin[pcd_pkg::S_URX] = 4'(pcd_pkg::UART_RX_PIN);
            next_slot_placed[pcd_pkg::S_UTX] = 1'b1;
            next_slot_placed[pcd_pkg::S_URX] = 1'b1;
        end
        for (int s = pcd_pkg::S_SCK; s < pcd_pkg::NSLOT; s++)
        begin
            found = 1'b0;
            for (int p = 0; p < pcd_pkg::NPIN; p++)
            begin
                if (slot_en[s] && !found && !used[p])
                begin
                    found = 1'b1;
                    used[p] = 1'b1;
                    next_pin_owner[p] = 5'(s);
                    next_slot_pin[s] = 4'(p);
                    next_slot_placed[s] = 1'b1;
                end
            end
        end
    end

    // Map registered once so the pads see a glitch-free owner
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_owner <= {pcd_pkg::NPIN{pcd_pkg::OWNER_GPIO}};
            slot_pin <= '0;
            slot_placed <= '0;
        end
        else
        begin
            pin_owner <= next_pin_owner;
            slot_pin <= next_slot_pin;
            slot_placed <= next_slot_placed;
        end
    end

    // Readable map of pins given to functions
    always_comb
    begin
        for (int p = 0; p < pcd_pkg::NPIN; p++)
            pin_assigned[p] = pin_owner[p] != pcd_pkg::OWNER_GPIO;
    end

    // ----------------------------------------
    // Pad input synchronisers
    // ----------------------------------------
    logic [pcd_pkg::NPIN-1:0] pad_s1;
    logic [pcd_pkg::NPIN-1:0] pad_s2;
    logic [pcd_pkg::NPIN-1:0] pad_s3;
    logic [pcd_pkg::NPIN-1:0] pad_level;

    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad_s1 <= '1;
            pad_s2 <= '1;
            pad_s3 <= '1;
            pad_level <= '1;
        end
        else
        begin
            pad_s1 <= pad_in;
            pad_s2 <= pad_s1;
            pad_s3 <= pad_s2;
            for (int p = 0; p < pcd_pkg::NPIN; p++)
                if (pad_s2[p] == pad_s3[p])
                    pad_level[p] <= pad_s3[p];
        end
    end

    // ----------------------------------------
    // Pad drive
    // ----------------------------------------
    function automatic logic is_twowire(input logic [4:0] owner);
        is_twowire = owner == 5'(pcd_pkg::S_SDA) || owner == 5'(pcd_pkg::S_SCL);
    endfunction : is_twowire

    logic [pcd_pkg::NPIN-1:0] next_pad_value;
    logic [pcd_pkg::NPIN-1:0] next_pad_oe_n;
    logic [pcd_pkg::NPIN-1:0] pin_want;
    logic [pcd_pkg::NPIN-1:0] pin_pp;

    // Value and drive request of each pin come from its current owner;
    // kept combinational so the clocked process below only registers
    always_comb
    begin
        next_pad_value = '0;
        next_pad_oe_n = '1;
        pin_want = '0;
        pin_pp = '0;
        for (int p = 0; p < pcd_pkg::NPIN; p++)
        begin
            if (pin_owner[p] == pcd_pkg::OWNER_GPIO)
            begin
                next_pad_value[p] = gpio_out[p];
                pin_want[p] = 1'b1;
            end
            else
            begin
                next_pad_value[p] = periph_out.value[pin_owner[p]];
                pin_want[p] = periph_out.drive[pin_owner[p]];
            end
            // Open-drain pins only pull low; two-wire lines never push high
            pin_pp[p] = pin_push_pull[p] && !is_twowire(pin_owner[p]);
            pin_want[p] = pin_want[p] && (pin_pp[p] || !next_pad_value[p]);
            // A disabled crossbar drives nothing
            next_pad_oe_n[p] = !(crossbar_enable_bit && pin_want[p]);
        end
    end

    // Pads registered so every pin output leaves a flip-flop
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pad.value <= '1;
            pad.oe_n <= '1;
        end
        else
        begin
            pad.value <= next_pad_value;
            pad.oe_n <= next_pad_oe_n;
        end
    end

    // ----------------------------------------
    // Inputs toward peripherals and port logic
    // ----------------------------------------
    // Unplaced inputs idle high, the usual idle level of serial lines
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            periph_in <= '1;
            gpio_in <= '1;
        end
        else
        begin
            gpio_in <= pad_level;
            for (int s = 0; s < pcd_pkg::NSLOT; s++)
                periph_in[s] <= slot_placed[s] ? pad_level[slot_pin[s]] : 1'b1;
        end
    end

endmodule : pcd_crossbar

// file: design/pcd_pkg.sv
// Constants, register map and carrier types of the priority crossbar decoder
package pcd_pkg;
    localparam int NPIN = 16;
    localparam int NSLOT = 17;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_ROUTE_FIRST = 10'h0E1;
    localparam logic [9:0] IDX_ROUTE_SECOND = 10'h0E2;
    localparam logic [9:0] IDX_ROUTE_THIRD = 10'h0E3;
    localparam logic [9:0] IDX_SKIP_P0 = 10'h0F0;
    localparam logic [9:0] IDX_SKIP_P1 = 10'h0F1;
    localparam logic [9:0] IDX_ASSIGNED = 10'h0F2;
    localparam logic [5:0] ROUTE_RESET = 6'h00;
    localparam logic [7:0] SKIP_RESET = 8'h00;
    localparam logic XBAR_EN_RESET = 1'b0;
    // Field positions
    localparam int B_UART = 0;
    localparam int B_SPI = 1;
    localparam int B_SMB = 2;
    localparam int B_SYSTEM_CLOCK_SIGNAL = 3;
    localparam int B_CMP_SYNC = 4;
    localparam int B_CMP_ASYNC = 5;
    localparam int B_CAP_LSB = 0;
    localparam int B_ECI = 3;
    localparam int B_T0 = 4;
    localparam int B_T1 = 5;
    localparam int B_XBAR_EN = 6;
    // Slots in priority order
    localparam int S_UTX = 0;
    localparam int S_URX = 1;
    localparam int S_SCK = 2;
    localparam int S_NSS = 5;
    localparam int S_SDA = 6;
    localparam int S_SCL = 7;
    localparam int S_CMP_SYNC = 8;
    localparam int S_CMP_ASYNC = 9;
    localparam int S_SYSTEM_CLOCK_SIGNAL = 10;
    localparam int S_CAPTURE_CHANNEL_IO_0 = 11;
    localparam int S_ECI = 14;
    localparam int S_T0 = 15;
    localparam int S_T1 = 16;
    localparam int UART_TX_PIN = 4;
    localparam int UART_RX_PIN = 5;
    localparam logic [4:0] OWNER_GPIO = 5'h1F;
    // Peripheral side: value and drive request per slot
    typedef struct packed {
        logic [NSLOT-1:0] value;
        logic [NSLOT-1:0] drive;
    } pcd_periph_t;
    // Pad side: value and active-low output enable per pin
    typedef struct packed {
        logic [NPIN-1:0] value;
        logic [NPIN-1:0] oe_n;
    } pcd_pad_t;
endpackage : pcd_pkg

// file: verification/pcd_crossbar_assertions.sv
// Port-level assertions for the crossbar decoder
`timescale 1ns/1ps
module pcd_crossbar_assertions (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic spi_four_wire,
    input wire pcd_pkg::pcd_periph_t periph_out,
    input wire logic [pcd_pkg::NSLOT-1:0] periph_in,
    input wire logic [pcd_pkg::NPIN-1:0] pin_push_pull,
    input wire pcd_pkg::pcd_pad_t pad
);
    logic [5:0] r1;
    logic xen;
    // Shadow of routing bits, taken at the same edge as the write lands
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r1 <= 6'h00;
            xen <= 1'b0;
        end
        else if (psel && penable && pready && pwrite)
        begin
            if (paddr == 12'h384)
                r1 <= pwdata[5:0];
            if (paddr == 12'h38C)
                xen <= pwdata[6];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_read(a);
        psel && penable && pready && !pwrite && paddr == a;
    endsequence
    // Three cycles cover the register-to-pad latency of two edges
    sequence s_tx_low;
        (r1[0] && xen && periph_out.drive[0] && !periph_out.value[0])[*3];
    endsequence
    a_first_top_zero: assert property (s_read(12'h384) |-> prdata[7:6] == 2'b00)
        else $error("top routing bits not zero");
    a_third_unused_zero: assert property (s_read(12'h38C) |-> prdata[5:0] == 6'h00)
        else $error("unused enable bits not zero");
    a_off_no_drive: assert property ((!xen)[*3] |-> &pad.oe_n)
        else $error("pin driven while crossbar off");
    a_tx_fixed_pin: assert property (s_tx_low |-> !pad.oe_n[4] && !pad.value[4])
        else $error("uart transmit not on pin 4");
    a_uart_unrouted: assert property ((!r1[0])[*4] |-> &periph_in[1:0])
        else $error("uart slot sees a pin while off");
    a_spi_unrouted: assert property ((!r1[1])[*4] |-> &periph_in[4:2])
        else $error("spi slot sees a pin while off");
    a_nss_three_wire: assert property ((!spi_four_wire)[*4] |-> periph_in[5])
        else $error("slave select placed in 3-wire mode");
    a_high_push_pull: assert property (&(pad.oe_n | ~pad.value | $past(pin_push_pull)))
        else $error("open-drain pin driven high");
endmodule : pcd_crossbar_assertions

bind pcd_crossbar pcd_crossbar_assertions pcd_crossbar_assertions_inst (
    .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .spi_four_wire(spi_four_wire), .periph_out(periph_out), .periph_in(periph_in),
    .pin_push_pull(pin_push_pull), .pad(pad)
);

// file: verification/pcd_pad_model.sv
// Board-side model of the package pins
`timescale 1ns/1ps
module pcd_pad_model (
    input wire pcd_pkg::pcd_pad_t pad,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic [15:0] pad_in
);
    // Driven pad wins; a released pin shows an outside driver or the pull-up
    assign pad_in = (~pad.oe_n & pad.value) | (pad.oe_n & (~ext_en | ext_val));
endmodule : pcd_pad_model

// file: verification/pcd_crossbar_tb_top.sv
// Self-checking bench for the crossbar decoder
`timescale 1ns/1ps
module pcd_crossbar_tb_top;
    logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fw = 1'b0, chk = 1'b0, xen;
    pcd_pkg::pcd_periph_t pout = '0;
    pcd_pkg::pcd_pad_t pad;
    logic [16:0] periph_in;
    logic [15:0] gpio_out = 16'h0, ppull = 16'h0, gpio_in, pad_in, ext_en = 16'h0, ext_val = 16'h0, sk;
    logic [5:0] r1, r2;
    logic [64:0] exp_q[$];
    logic [64:0] got, e;
    int n_errors = 0, n_compared = 0, seed = 28372;
    int pin_of[17];
    int own[16];
    pcd_crossbar pcd_crossbar_inst (
        .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .spi_four_wire(fw), .periph_out(pout), .periph_in(periph_in), .gpio_out(gpio_out),
        .pin_push_pull(ppull), .gpio_in(gpio_in), .pad_in(pad_in), .pad(pad)
    );
    pcd_pad_model pcd_pad_model_inst (.pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    always #5 sys_clk = ~sys_clk;
    // Pops the oldest note on each read answer or pin sample
    always @(posedge sys_clk)
    begin
        if ((psel && penable && pready && !pwrite) || chk)
        begin
            got = chk ? {pad.oe_n, pad.value & ~pad.oe_n, periph_in, gpio_in} : {32'h0, pslverr, prdata};
            e = exp_q.pop_front();
            n_compared++;
            if (got !== e)
            begin
                n_errors++;
                $display("mismatch at %0t: got %h expected %h", $time, got, e);
            end
        end
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    // One APB transfer; a read notes d as the expected {error, data}
    task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d);
        int i;
        if (!w)
            exp_q.push_back({32'h0, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d[31:0];
        @(posedge sys_clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge sys_clk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1)
        begin
            n_errors++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    function automatic logic en(input int s);
        case (s)
            2, 3, 4: return r1[1];
            5: return r1[1] && fw;
            6, 7: return r1[2];
            8: return r1[4];
            9: return r1[5];
            10: return r1[3];
            11, 12, 13: return !r2[2] && (s - 11) < r2[1:0];
            14: return r2[3];
            15: return r2[4];
            default: return r2[5];
        endcase
    endfunction : en
    // Reference placement: fixed uart pins, then lowest free unskipped pin in priority order
    task automatic place();
        logic [15:0] used;
        int p;
        used = sk;
        pin_of = '{default: -1};
        own = '{default: -1};
        if (r1[0])
        begin
            pin_of[0] = 4;
            pin_of[1] = 5;
            used[5:4] = 2'b11;
        end
        for (int s = 2; s < 17; s++)
        begin
            p = 0;
            while (p < 16 && used[p])
                p++;
            if (en(s) && p < 16)
            begin
                pin_of[s] = p;
                used[p] = 1'b1;
            end
        end
        for (int s = 0; s < 17; s++)
            if (pin_of[s] >= 0)
                own[pin_of[s]] = s;
    endtask : place
    // Expected pads, input levels and assigned-pin status for the current setup
    task automatic check_pins();
        logic [15:0] eo, ev, lvl, asg;
        logic [16:0] epi;
        logic d, v;
        int s;
        place();
        repeat (8) @(posedge sys_clk);
        for (int p = 0; p < 16; p++)
        begin
            s = own[p];
            d = (s < 0) ? 1'b1 : pout.drive[s];
            v = (s < 0) ? gpio_out[p] : pout.value[s];
            d = xen && d && !(v && (!ppull[p] || s == 6 || s == 7));
            eo[p] = !d;
            ev[p] = d && v;
            lvl[p] = d ? v : (!ext_en[p] || ext_val[p]);
            asg[p] = s >= 0;
        end
        for (int k = 0; k < 17; k++)
            epi[k] = pin_of[k] < 0 ? 1'b1 : lvl[pin_of[k]];
        exp_q.push_back({eo, ev, epi, lvl});
        chk <= 1'b1;
        @(posedge sys_clk);
        chk <= 1'b0;
        apb(1'b0, 12'h3C8, {17'h0, asg});
    endtask : check_pins
    initial
    begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        apb(1'b0, 12'h384, 33'h0);
        apb(1'b0, 12'h38C, 33'h0);
        apb(1'b1, 12'h388, 32'hFFFFFFFF);
        apb(1'b0, 12'h388, 33'h3F);
        apb(1'b0, 12'h3FC, 33'h100000000);
        $display("register test done");
        for (int t = 0; t < 40; t++)
        begin
            r1 = 6'($random(seed));
            r2 = 6'($random(seed));
            sk = 16'($random(seed));
            xen = t != 0;
            if (t == 1)
                {r1, sk} = {6'h01, 16'h0030};
            if (t == 2 || t == 3)
                r1 = 6'h06;
            if (t >= 4 && t < 12)
                r2[2:0] = 3'(t - 4);
            if (t == 12)
                sk[12] = 1'b1;
            fw <= (t == 2) ? 1'b0 : (t == 3) ? 1'b1 : 1'($random(seed));
            pout <= {17'($random(seed)), 17'($random(seed))};
            gpio_out <= 16'($random(seed));
            ppull <= 16'($random(seed));
            ext_en <= 16'($random(seed));
            ext_val <= 16'($random(seed));
            apb(1'b1, 12'h384, {26'($random(seed)), r1});
            apb(1'b0, 12'h384, {27'h0, r1});
            apb(1'b1, 12'h388, {26'($random(seed)), r2});
            apb(1'b1, 12'h3C0, {24'h0, sk[7:0]});
            apb(1'b1, 12'h3C4, {24'h0, sk[15:8]});
            apb(1'b1, 12'h38C, {25'h0, xen, 6'h0});
            check_pins();
            $display("routing test %0d done", t);
        end
        complete_run();
    end
endmodule : pcd_crossbar_tb_top
